/* core/drc_params.svh */
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

// Clock period and rounding helpers
`define DRC_CLK_NS       10
`define DRC_CEIL(t)      (((t) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
`define DRC_FLOOR(t)     ((t) / `DRC_CLK_NS)

// Fastest speed grade figures, in ns
`define DRC_T_RC_NS      110
`define DRC_T_RAC_NS     60
`define DRC_T_CAC_NS     15
`define DRC_T_AA_NS      30
`define DRC_T_RCD_NS     20
`define DRC_T_RAS_NS     60
`define DRC_T_CP_NS      10
`define DRC_T_PC_NS      40
`define DRC_T_REF_NS     8200000
`define DRC_T_INIT_NS    200000
`define DRC_REF_ROWS     512
`define DRC_INIT_REFS    8

// Cycle counts derived from the figures above
`define DRC_RCD_CYC      `DRC_CEIL(`DRC_T_RCD_NS)
`define DRC_COL_CYC      (`DRC_CEIL(`DRC_T_RAC_NS) - `DRC_RCD_CYC)
`define DRC_PRE_CYC      (`DRC_CEIL(`DRC_T_RC_NS) - `DRC_CEIL(`DRC_T_RAS_NS))
`define DRC_RAS_CYC      `DRC_CEIL(`DRC_T_RAS_NS)
`define DRC_CP_CYC       `DRC_CEIL(`DRC_T_CP_NS)
`define DRC_REF_IVL_CYC  `DRC_FLOOR(`DRC_T_REF_NS / `DRC_REF_ROWS)
`define DRC_INIT_CYC     `DRC_CEIL(`DRC_T_INIT_NS)

// Field layout of the user word address
`define DRC_COL_LSB      0
`define DRC_ROW_LSB      9

`endif

/* core/drc_pkg.sv */
package drc_pkg;

    typedef enum logic [3:0] {
        DRC_S_INIT = 4'h0,
        DRC_S_IDLE = 4'h1,
        DRC_S_ROW  = 4'h2,
        DRC_S_COL  = 4'h3,
        DRC_S_CPRE = 4'h4,
        DRC_S_PRE  = 4'h5,
        DRC_S_RREF = 4'h6,
        DRC_S_CBRC = 4'h7,
        DRC_S_CBRR = 4'h8
    } drc_state_t;

    typedef struct packed {
        logic       write;
        logic [8:0] row;
        logic [8:0] col;
        logic [3:0] wdata;
    } drc_req_t;

endpackage

/* core/drc_ctrl.sv */
// How it works
// RL1 - Memory holds 262,144 four-bit words; every access moves all four lines.
// RL2 - Eighteen-bit address goes out as row half then column half on nine pins.
// RL3 - Device latches the row on the falling row strobe, before any column.
// RL4 - Device latches the column on the falling column strobe after the row.
// RL5 - We present row on the edge row strobe falls, column no later than the column strobe fall.
// RL6 - Device latches pass through; late addresses count as column address.
// RL7 - Write strobe low starts a write, high selects a read.
// RL8 - Device ignores data lines during reads.
// RL9 - Device supports early, gate-controlled delayed and read-modify-write.
// RL10 - Write data latched on the later of write or column strobe fall.
// RL11 - Early write: write strobe falls first, data sampled at column fall.
// RL12 - Delayed write: write strobe falls later, data sampled at its fall.
// RL13 - Outputs float until column strobe falls; read data keeps polarity.
// RL14 - Read data valid after latest of row, column, address access times.
// RL15 - Late gate fall gives data a fixed gate access time later.
// RL16 - Read data stays valid until column strobe or gate rises.
// RL17 - Outputs stay floating through an entire early write.
// RL18 - We issue 512 refresh cycles within every 8.2 ms.
// RL19 - Device accepts row-only, column-before-row and hidden refresh.
// RL20 - Device supports fast page column cycles and read-modify-write.
// RL21 - Successive random cycles spaced at least the random cycle time.
// RL22 - Successive page column cycles spaced at least the page cycle time.
// RL23 - After power-up: strobes high 200 us, then eight row-only cycles.
// RL24 - With the internal counter, the eight wake cycles are column-first.
// RL25 - Row-only refresh steps a nine-bit row counter through all rows.
`timescale 1ns/1ps
`include "drc_params.svh"

module drc_ctrl #(
    parameter int INIT_CYCLES = `DRC_INIT_CYC,
    parameter bit USE_CBR     = 1'b0
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RSTN,
    input  wire logic       REQ_VALID,
    output logic            REQ_READY,
    input  wire logic       REQ_WRITE,
    input  wire logic [17:0] REQ_ADDR,
    input  wire logic [3:0] REQ_WDATA,
    output logic            RSP_VALID,
    output logic [3:0]      RSP_RDATA,
    output logic            INIT_DONE,
    output logic [8:0]      DRAM_ADDR,
    output logic            DRAM_RAS_N,
    output logic            DRAM_CAS_N,
    output logic            DRAM_WE_N,
    output logic            DRAM_OE_N,
    output logic [3:0]      DRAM_DQ_O,
    output logic            DRAM_DQ_OE_N,
    input  wire logic [3:0] DRAM_DQ_I
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]          rst_sync_q;
    logic                rst_n;
    drc_pkg::drc_state_t state_q;
    logic [3:0]          cnt_q;
    logic [14:0]         tmr_q;
    logic                tmr_zero;
    logic                ref_pend_q;
    logic [3:0]          init_left_q;
    logic [8:0]          ref_row_q;
    logic                ref_go;
    logic                ref_start;
    logic                page_hit;
    logic                accept;
    drc_pkg::drc_req_t   req_q;
    logic [8:0]          req_row;
    logic [8:0]          req_col;

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Row half and column half of the word address [RL2]
    assign req_row  = REQ_ADDR[`DRC_ROW_LSB +: 9];
    assign req_col  = REQ_ADDR[`DRC_COL_LSB +: 9];
    assign ref_go   = (init_left_q != 4'h0) | ref_pend_q;
    assign ref_start = (state_q == drc_pkg::DRC_S_IDLE) & ref_go;
    // Staying in the row only while no refresh waits also bounds the row
    // strobe low time far below its maximum
    assign page_hit = (state_q == drc_pkg::DRC_S_COL) & (cnt_q == 4'h0)
                    & (req_row == req_q.row) & ~ref_go;
    assign REQ_READY = ((state_q == drc_pkg::DRC_S_IDLE) & ~ref_go)
                     | page_hit;
    assign accept   = REQ_VALID & REQ_READY;
    assign INIT_DONE = (state_q != drc_pkg::DRC_S_INIT)
                     & (init_left_q == 4'h0);

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            req_q <= '0;
        else if (accept)
            req_q <= '{write: REQ_WRITE, row: req_row, col: req_col,
                       wdata: REQ_WDATA};
    end

    ////////////////////////////////////////////////////////////////////////
    // One timer: power-up pause first, then the refresh interval
    assign tmr_zero = (tmr_q == 15'h0000);

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            tmr_q <= 15'(INIT_CYCLES - 1);
        else if (tmr_zero)
            tmr_q <= 15'(`DRC_REF_IVL_CYC - 1);  // [RL18]
        else
            tmr_q <= tmr_q - 15'h0001;
    end

    // A tick landing on the start cycle stays pending, so none is lost
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            ref_pend_q <= 1'b0;
        else
            ref_pend_q <= (tmr_zero & (state_q != drc_pkg::DRC_S_INIT))
                        | (ref_pend_q & ~(ref_start
                                          & (init_left_q == 4'h0)));  // [RL18]
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            init_left_q <= 4'h0;
        else if ((state_q == drc_pkg::DRC_S_INIT) && tmr_zero)
            init_left_q <= 4'(`DRC_INIT_REFS);  // [RL23] [RL24]
        else if (ref_start && (init_left_q != 4'h0))
            init_left_q <= init_left_q - 4'h1;
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            ref_row_q <= 9'h000;
        else if (ref_start && !USE_CBR)
            ref_row_q <= ref_row_q + 9'h001;  // [RL25]
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe sequencer; all DRAM pins come straight from flip-flops
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q      <= drc_pkg::DRC_S_INIT;
            cnt_q        <= 4'h0;
            DRAM_ADDR    <= 9'h000;
            DRAM_RAS_N   <= 1'b1;
            DRAM_CAS_N   <= 1'b1;
            DRAM_WE_N    <= 1'b1;
            DRAM_OE_N    <= 1'b1;
            DRAM_DQ_O    <= 4'h0;
            DRAM_DQ_OE_N <= 1'b1;
            RSP_VALID    <= 1'b0;
            RSP_RDATA    <= 4'h0;
        end
        else
        begin
            RSP_VALID <= 1'b0;
            if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
            case (state_q)
                drc_pkg::DRC_S_INIT:
                begin
                    // Both strobes stay high through the pause [RL23]
                    if (tmr_zero)
                        state_q <= drc_pkg::DRC_S_IDLE;
                end
                drc_pkg::DRC_S_IDLE:
                begin
                    if (ref_go && USE_CBR)
                    begin
                        // Column strobe first selects internal counter [RL24]
                        state_q    <= drc_pkg::DRC_S_CBRC;
                        DRAM_CAS_N <= 1'b0;
                        cnt_q      <= 4'(`DRC_CP_CYC - 1);
                    end
                    else if (ref_go)
                    begin
                        state_q    <= drc_pkg::DRC_S_RREF;
                        DRAM_ADDR  <= ref_row_q;  // [RL25]
                        DRAM_RAS_N <= 1'b0;  // [RL23]
                        cnt_q      <= 4'(`DRC_RAS_CYC - 1);
                    end
                    else if (accept)
                    begin
                        // Row set up with the strobe edge, write strobe and
                        // data ahead of the column strobe [RL5] [RL11]
                        // Early writes only; no delayed write [RL12]
                        state_q      <= drc_pkg::DRC_S_ROW;
                        DRAM_ADDR    <= req_row;  // [RL5]
                        DRAM_RAS_N   <= 1'b0;
                        DRAM_WE_N    <= ~REQ_WRITE;  // [RL7]
                        DRAM_DQ_O    <= REQ_WDATA;
                        DRAM_DQ_OE_N <= ~REQ_WRITE;  // [RL11]
                        cnt_q        <= 4'(`DRC_RCD_CYC - 1);
                    end
                end
                drc_pkg::DRC_S_ROW:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q    <= drc_pkg::DRC_S_COL;
                        DRAM_ADDR  <= req_q.col;  // [RL5]
                        DRAM_CAS_N <= 1'b0;
                        DRAM_OE_N  <= req_q.write;
                        cnt_q      <= 4'(`DRC_COL_CYC - 1);
                    end
                end
                drc_pkg::DRC_S_COL:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        // Row and column access both met by now [RL14]
                        if (!req_q.write)
                        begin
                            RSP_RDATA <= DRAM_DQ_I;  // [RL16]
                            RSP_VALID <= 1'b1;
                        end
                        DRAM_CAS_N <= 1'b1;
                        DRAM_OE_N  <= 1'b1;
                        if (accept)
                        begin
                            state_q      <= drc_pkg::DRC_S_CPRE;
                            DRAM_ADDR    <= req_col;
                            DRAM_WE_N    <= ~REQ_WRITE;  // [RL7]
                            DRAM_DQ_O    <= REQ_WDATA;
                            DRAM_DQ_OE_N <= ~REQ_WRITE;  // [RL11]
                            cnt_q        <= 4'(`DRC_CP_CYC - 1);
                        end
                        else
                        begin
                            state_q      <= drc_pkg::DRC_S_PRE;
                            DRAM_RAS_N   <= 1'b1;
                            DRAM_WE_N    <= 1'b1;
                            DRAM_DQ_OE_N <= 1'b1;
                            cnt_q        <= 4'(`DRC_PRE_CYC - 1);
                        end
                    end
                end
                drc_pkg::DRC_S_CPRE:
                begin
                    // Precharge plus column phase covers the page cycle
                    if (cnt_q == 4'h0)
                    begin
                        state_q    <= drc_pkg::DRC_S_COL;  // [RL22]
                        DRAM_CAS_N <= 1'b0;
                        DRAM_OE_N  <= req_q.write;
                        cnt_q      <= 4'(`DRC_COL_CYC - 1);
                    end
                end
                drc_pkg::DRC_S_RREF:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q    <= drc_pkg::DRC_S_PRE;
                        DRAM_RAS_N <= 1'b1;
                        cnt_q      <= 4'(`DRC_PRE_CYC - 1);
                    end
                end
                drc_pkg::DRC_S_CBRC:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q    <= drc_pkg::DRC_S_CBRR;
                        DRAM_RAS_N <= 1'b0;
                        cnt_q      <= 4'(`DRC_RAS_CYC - 1);
                    end
                end
                drc_pkg::DRC_S_CBRR:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q    <= drc_pkg::DRC_S_PRE;
                        DRAM_RAS_N <= 1'b1;
                        DRAM_CAS_N <= 1'b1;
                        cnt_q      <= 4'(`DRC_PRE_CYC - 1);
                    end
                end
                drc_pkg::DRC_S_PRE:
                begin
                    // Low time plus precharge spans the random cycle
                    if (cnt_q == 4'h0)
                        state_q <= drc_pkg::DRC_S_IDLE;  // [RL21]
                end
                default:
                begin
                    state_q <= drc_pkg::DRC_S_IDLE;
                end
            endcase
        end
    end

endmodule

/* tb/drc_ctrl_props.sv */
`timescale 1ns/1ps
module drc_ctrl_props (
    input wire logic       CLK_SYS,
    input wire logic       RSTN,
    input wire logic       REQ_READY,
    input wire logic       RSP_VALID,
    input wire logic [3:0] RSP_RDATA,
    input wire logic       INIT_DONE,
    input wire logic [8:0] DRAM_ADDR,
    input wire logic       DRAM_RAS_N,
    input wire logic       DRAM_CAS_N,
    input wire logic       DRAM_WE_N,
    input wire logic       DRAM_OE_N,
    input wire logic       DRAM_DQ_OE_N,
    input wire logic [3:0] DRAM_DQ_I
);
    logic       cbr_q;
    logic       row_seen_q;
    logic [8:0] row_last_q;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////
    // Column strobe low while the row strobe is high marks a counter refresh
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            cbr_q <= 1'b0;
        else
            cbr_q <= !DRAM_CAS_N && (DRAM_RAS_N || cbr_q);
    end
    // Row-only refresh ends with the column strobe high all along
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            row_seen_q <= 1'b0;
            row_last_q <= 9'h000;
        end
        else if ($rose(DRAM_RAS_N) && $past(DRAM_CAS_N))
        begin
            row_seen_q <= 1'b1;
            row_last_q <= DRAM_ADDR;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_ras_low_min: assert property (
        $fell(DRAM_RAS_N) |-> !DRAM_RAS_N[*6])
        else $error("row strobe low too short");
    a_ras_pre_min: assert property (
        $rose(DRAM_RAS_N) |-> DRAM_RAS_N[*5])
        else $error("row strobe precharge too short");
    a_col_after_row: assert property (
        $fell(DRAM_CAS_N) && !DRAM_RAS_N |-> !$past(DRAM_RAS_N, 2))
        else $error("column strobe too early");
    a_row_addr_hold: assert property (
        !DRAM_RAS_N && !$past(DRAM_RAS_N) && DRAM_CAS_N
        && $past(DRAM_CAS_N) |-> $stable(DRAM_ADDR))
        else $error("row address moved");
    a_col_addr_hold: assert property (
        !DRAM_CAS_N && !$past(DRAM_CAS_N) |-> $stable(DRAM_ADDR))
        else $error("column address moved");
    a_early_write: assert property (
        $fell(DRAM_CAS_N) && !DRAM_WE_N |-> !$past(DRAM_WE_N))
        else $error("write strobe after column");
    a_write_drive: assert property (
        !DRAM_WE_N && !DRAM_CAS_N |-> !DRAM_DQ_OE_N && DRAM_OE_N)
        else $error("write not driven");
    a_read_gate: assert property (
        !DRAM_CAS_N && DRAM_WE_N && !DRAM_RAS_N && !cbr_q
        |-> !DRAM_OE_N && DRAM_DQ_OE_N)
        else $error("read gate wrong");
    a_read_answer: assert property (
        $fell(DRAM_CAS_N) && DRAM_WE_N && !DRAM_RAS_N |-> ##4 RSP_VALID)
        else $error("read answer late");
    a_rsp_data: assert property (
        RSP_VALID |-> RSP_RDATA == $past(DRAM_DQ_I))
        else $error("read data wrong");
    a_ready_init: assert property (
        !INIT_DONE |-> !REQ_READY)
        else $error("request taken before wake");
    a_ref_row_step: assert property (
        $rose(DRAM_RAS_N) && $past(DRAM_CAS_N) && row_seen_q
        |-> DRAM_ADDR == row_last_q + 9'h001)
        else $error("refresh row not stepped");
    c_read: cover property (RSP_VALID);
    c_page: cover property ($fell(DRAM_CAS_N) && !$past(DRAM_RAS_N, 5));
    c_wake: cover property ($rose(INIT_DONE));
    c_cbr: cover property ($fell(DRAM_CAS_N) && DRAM_RAS_N);
endmodule

/* tb/drc_dram_model.sv */
`timescale 1ns/1ps
module drc_dram_model (
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic       oe_n,
    input  wire logic [8:0] addr,
    input  wire logic [3:0] din,
    output logic      [3:0] dq,
    output int              ref_cnt
);
    logic [3:0] mem [0:262143];
    logic [8:0] row_q = 9'h000;
    logic [8:0] col_q = 9'h000;
    logic [3:0] out_q = 4'h0;
    // Starts set so the first rise out of X is not counted as a refresh
    logic       cas_q = 1'b1;
    logic       drv;
    initial ref_cnt = 0;
    always @(negedge ras_n)
    begin
        row_q = addr;
        cas_q = 1'b0;
    end
    always @(negedge cas_n)
    begin
        if (!ras_n)
        begin
            col_q = addr;
            cas_q = 1'b1;
            if (!we_n)
                mem[{row_q, col_q}] = din;
        end
    end
    always @(negedge we_n)
        if (!ras_n && !cas_n)
            mem[{row_q, col_q}] = din;
    // Row strobe cycle with no column strobe fall while it is low is a refresh
    always @(posedge ras_n)
        if (!cas_q)
            ref_cnt = ref_cnt + 1;
    assign drv = !ras_n && !cas_n && !oe_n && we_n;
    always @(negedge drv)
        out_q = mem[{row_q, col_q}];
    // Released lines show the inverse so a stale value cannot pass
    assign dq = drv ? mem[{row_q, col_q}] : ~out_q;
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic        CLK_SYS = 1'b0;
    logic        RSTN = 1'b0;
    logic        REQ_VALID = 1'b0;
    logic        REQ_WRITE = 1'b0;
    logic [17:0] REQ_ADDR = 18'h0_0000;
    logic [3:0]  REQ_WDATA = 4'h0;
    logic        REQ_READY, RSP_VALID, INIT_DONE;
    logic [3:0]  RSP_RDATA, DRAM_DQ_O, DRAM_DQ_I, dq_bus;
    logic [8:0]  DRAM_ADDR;
    logic        DRAM_RAS_N, DRAM_CAS_N, DRAM_WE_N, DRAM_OE_N, DRAM_DQ_OE_N;
    logic [3:0]  rq [$];
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          ref_cnt;
    logic        c_valid = 1'b0;
    logic        c_ready, c_rsp, c_done;
    logic [3:0]  c_rdata, c_dq_o, c_dq_i, c_dq_bus;
    logic [8:0]  c_addr;
    logic        c_ras_n, c_cas_n, c_we_n, c_oe_n, c_dq_oe_n;
    int          c_ref_cnt;
    logic [17:0] ta [6] = '{18'h0_0000, 18'h3_ffff, 18'h1_5aa5,
                            18'h0_1234, 18'h2_a400, 18'h2_a5ff};
    logic [3:0]  td [6] = '{4'h5, 4'ha, 4'hf, 4'h0, 4'h3, 4'hc};
    initial forever #5 CLK_SYS = ~CLK_SYS;
    drc_ctrl #(.INIT_CYCLES(20), .USE_CBR(1'b0)) dut_u (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
        .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
        .INIT_DONE(INIT_DONE), .DRAM_ADDR(DRAM_ADDR), .DRAM_RAS_N(DRAM_RAS_N),
        .DRAM_CAS_N(DRAM_CAS_N), .DRAM_WE_N(DRAM_WE_N), .DRAM_OE_N(DRAM_OE_N),
        .DRAM_DQ_O(DRAM_DQ_O), .DRAM_DQ_OE_N(DRAM_DQ_OE_N),
        .DRAM_DQ_I(DRAM_DQ_I));
    // Undriven data lines show the inverse of the controller's last value
    assign dq_bus = DRAM_DQ_OE_N ? ~DRAM_DQ_O : DRAM_DQ_O;
    drc_dram_model mem_u (.ras_n(DRAM_RAS_N), .cas_n(DRAM_CAS_N),
        .we_n(DRAM_WE_N), .oe_n(DRAM_OE_N), .addr(DRAM_ADDR), .din(dq_bus),
        .dq(DRAM_DQ_I), .ref_cnt(ref_cnt));
    // Second controller runs the counter refresh form
    drc_ctrl #(.INIT_CYCLES(20), .USE_CBR(1'b1)) dut_cbr_u (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REQ_VALID(c_valid),
        .REQ_READY(c_ready), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
        .REQ_WDATA(REQ_WDATA), .RSP_VALID(c_rsp), .RSP_RDATA(c_rdata),
        .INIT_DONE(c_done), .DRAM_ADDR(c_addr), .DRAM_RAS_N(c_ras_n),
        .DRAM_CAS_N(c_cas_n), .DRAM_WE_N(c_we_n), .DRAM_OE_N(c_oe_n),
        .DRAM_DQ_O(c_dq_o), .DRAM_DQ_OE_N(c_dq_oe_n), .DRAM_DQ_I(c_dq_i));
    assign c_dq_bus = c_dq_oe_n ? ~c_dq_o : c_dq_o;
    drc_dram_model mem_cbr_u (.ras_n(c_ras_n), .cas_n(c_cas_n),
        .we_n(c_we_n), .oe_n(c_oe_n), .addr(c_addr), .din(c_dq_bus),
        .dq(c_dq_i), .ref_cnt(c_ref_cnt));
    always @(posedge CLK_SYS)
        if (RSP_VALID === 1'b1)
            rq.push_back(RSP_RDATA);
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge CLK_SYS)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %0h got %0h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    // Leaves the request raised so a following call can chain a page access
    task automatic req(input logic w, input logic [17:0] a,
                       input logic [3:0] d);
        int n;
        n = 0;
        REQ_VALID = 1'b1;
        REQ_WRITE = w;
        REQ_ADDR = a;
        REQ_WDATA = d;
        while (REQ_READY !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        chk("req_ready", 8'h01, 8'(REQ_READY));
        tick(1);
    endtask
    task automatic rd_chk(input logic [3:0] exp);
        int n;
        n = 0;
        REQ_VALID = 1'b0;
        while (rq.size() == 0 && n < 30)
        begin
            tick(1);
            n++;
        end
        chk("rsp_rdata", 8'(exp),
            rq.size() ? 8'(rq.pop_front()) : 8'hxx);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        tick(8);
        chk("ras_n_rst", 8'h01, 8'(DRAM_RAS_N));
        chk("cas_n_rst", 8'h01, 8'(DRAM_CAS_N));
        chk("dq_oe_n_rst", 8'h01, 8'(DRAM_DQ_OE_N));
        chk("ready_rst", 8'h00, 8'(REQ_READY));
        tick(8);
        RSTN = 1'b1;
    endtask
    task automatic t_init();
        int n;
        n = 0;
        while (INIT_DONE !== 1'b1 && n < 3000)
        begin
            tick(1);
            n++;
        end
        chk("init_done", 8'h01, 8'(INIT_DONE));
        // The flag rises as the last wake cycle starts; let both finish
        tick(16);
        chk("wake_refresh", 8'h08, 8'(ref_cnt));
        chk("cbr_done", 8'h01, 8'(c_done));
        chk("cbr_wake", 8'h08, 8'(c_ref_cnt));
    endtask
    task automatic t_rw();
        for (int i = 0; i < 6; i++)
            req(1'b1, ta[i], td[i]);
        for (int i = 0; i < 4; i++)
        begin
            req(1'b0, ta[i], 4'h0);
            rd_chk(td[i]);
        end
    endtask
    task automatic t_page();
        req(1'b0, ta[4], 4'h0);
        req(1'b0, ta[5], 4'h0);
        rd_chk(td[4]);
        rd_chk(td[5]);
    endtask
    task automatic t_refresh();
        int r0;
        r0 = ref_cnt;
        tick(3210);
        r0 = ref_cnt - r0;
        chk("refresh_cnt", 8'h01, 8'(r0 inside {[2:3]}));
        req(1'b0, ta[1], 4'h0);
        rd_chk(td[1]);
    endtask
    // Write then same-row read on the counter refresh controller
    task automatic t_cbr();
        int n;
        n = 0;
        c_valid = 1'b1;
        REQ_WRITE = 1'b1;
        REQ_ADDR = ta[2];
        REQ_WDATA = td[1];
        for (int i = 0; i < 2; i++)
        begin
            while (c_ready !== 1'b1 && n < 2000)
            begin
                tick(1);
                n++;
            end
            tick(1);
            REQ_WRITE = 1'b0;
        end
        c_valid = 1'b0;
        while (c_rsp !== 1'b1 && n < 2100)
        begin
            tick(1);
            n++;
        end
        chk("cbr_rdata", 8'(td[1]), 8'(c_rdata));
    endtask
    initial
    begin
        t_reset();
        t_init();
        t_rw();
        t_page();
        t_refresh();
        t_cbr();
        report_and_stop();
    end
endmodule
bind drc_ctrl drc_ctrl_props chk_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .INIT_DONE(INIT_DONE), .DRAM_ADDR(DRAM_ADDR), .DRAM_RAS_N(DRAM_RAS_N),
    .DRAM_CAS_N(DRAM_CAS_N), .DRAM_WE_N(DRAM_WE_N), .DRAM_OE_N(DRAM_OE_N),
    .DRAM_DQ_OE_N(DRAM_DQ_OE_N), .DRAM_DQ_I(DRAM_DQ_I));
